// *** verilog/ciu_pkg.sv ***
/*
  Shared constants of the CPU interrupt unit: register offsets,
  control field positions, reset values and timing counts.
  Assumes a 32-bit APB register bus with word-aligned registers.
*/
package ciu_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] CIU_ADDR_CONTROL      = 8'h00;
  localparam logic [7:0] CIU_ADDR_PERIPH_EN    = 8'h04;
  localparam logic [7:0] CIU_ADDR_PERIPH_FLAG  = 8'h08;
  localparam logic [7:0] CIU_ADDR_OPTION       = 8'h0c;
  localparam logic [7:0] CIU_ADDR_CORE_STATUS  = 8'h10;
  localparam logic [7:0] CIU_ADDR_SHADOW_BASE  = 8'h40;
  localparam logic [7:0] CIU_ADDR_SHADOW_LAST  = 8'h5c;
  localparam int         CIU_SHADOW_COUNT      = 8;
  localparam logic [4:0] CIU_SHADOW_BANK       = 5'h1f;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int CIU_BIT_GIE      = 7;
  localparam int CIU_BIT_PERIPHERAL_IRQ_ENABLE     = 6;
  localparam int CIU_BIT_T0_EN    = 5;
  localparam int CIU_BIT_EXT_EN   = 4;
  localparam int CIU_BIT_PC_EN    = 3;
  localparam int CIU_BIT_T0_FLAG  = 2;
  localparam int CIU_BIT_EXT_FLAG = 1;
  localparam int CIU_BIT_PC_FLAG  = 0;
  localparam logic [7:0] CIU_CONTROL_RESET = 8'h00;

  // ****************************************************************
  // Status register: timeout and powerdown bits are not shadowed
  // ****************************************************************
  localparam logic [7:0] CIU_STATUS_SAVE_MASK = 8'he7;

  // ****************************************************************
  // Vector and timing
  // ****************************************************************
  localparam logic [14:0] CIU_IRQ_VECTOR  = 15'h0004;
  localparam int          CIU_Q_PER_CYCLE = 4;
  localparam int          CIU_LAT_MIN     = 3;
  localparam int          CIU_LAT_MAX_SYNC  = 4;
  localparam int          CIU_LAT_MAX_ASYNC = 5;

  typedef enum logic [1:0] {
    CIU_RUN    = 2'b00,
    CIU_FLUSH  = 2'b01,
    CIU_VECTOR = 2'b11,
    CIU_WAKE   = 2'b10
  } ciu_state_type;

endpackage

// *** verilog/ciu_sync_edge.sv ***
/*
  Two-flop synchroniser with selectable edge detector.
  Assumes the pin input is asynchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module ciu_sync_edge (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin,
  input  wire logic rising_sel,
  output logic      edge_pulse
);
  logic       meta;
  logic       sync;
  logic       last;
  logic [2:0] fill;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
      fill <= 3'h0;
    end else begin
      meta <= pin;
      sync <= meta;
      last <= sync;
      fill <= {fill[1:0], 1'b1};
    end
  end

  // Only the second flop and its delayed copy last feed the detector
  // Held off until last holds a real pin sample: a pin idling high would fake an edge after reset
  always_comb begin
    if (!fill[2]) begin
      edge_pulse = 1'b0;
    end else if (rising_sel) begin
      edge_pulse = sync & ~last;
    end else begin
      edge_pulse = ~sync & last;
    end
  end
endmodule
`default_nettype wire

// *** verilog/ciu_shadow.sv ***
/*
  Shadow register bank for context saved on interrupt entry.
  Assumes the core supplies live context and takes restored context
  on return; software may rewrite any shadow word over the bus.
*/
`timescale 1ns/1ps
`default_nettype none
module ciu_shadow
  import ciu_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int COUNT = 8
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     save,
  input  wire logic [COUNT*WIDTH-1:0]   live_ctx,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(COUNT)-1:0] wr_idx,
  input  wire logic [WIDTH-1:0]         wr_data,
  output logic      [COUNT*WIDTH-1:0]   shadow_ctx
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_ctx <= '0;
    end else if (save) begin
      shadow_ctx <= live_ctx;
    end else if (wr_en) begin
      shadow_ctx[wr_idx*WIDTH +: WIDTH] <= wr_data;
    end
  end
endmodule
`default_nettype wire

// *** verilog/ciu_top.sv ***
/*
  CPU interrupt unit: flags, enables, vectoring, sleep wake and
  automatic context save and restore, with an APB register slave.
  Assumes the core sequencer strobes cycle_tick once per instruction
  cycle, reports return and sleep, and obeys redirect requests.
*/
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Any reset clears all interrupt enables
// - Interrupt needs global and own enables; peripheral sources also the peripheral enable
// - Flags set regardless of enable bits
// - Entry flushes, clears global, pushes, saves, vectors
// - In service, events flag but do not redirect unless software sets global enable
// - Return pops, restores context, sets global enable
// - Pending interrupts serviced once global set
// - Latency three to five instruction cycles
// - Enabled wake source wakes core from sleep
// - Instruction after sleep executes before vector
// - External pin edge selectable, asynchronous
// - Selected edge sets external flag
// - Entry copies core context into shadows
// - Return restores shadows, software edits kept
// - Shadows in bank 31, read and write
// - Control register bit layout, enables high
// - Pin-change flag read-only, follows source flags
// - Timer0 overflow sets its flag
// - External flag may set in Q4-Q1
module ciu_top
  import ciu_pkg::*;
#(
  parameter int NPERIPH = 8
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               cycle_tick,
  input  wire logic               timer0_overflow,
  input  wire logic               ext_pin,
  input  wire logic               pin_change_any,
  input  wire logic [NPERIPH-1:0] periph_event,
  input  wire logic [NPERIPH-1:0] periph_wake_capable,
  input  wire logic               return_from_irq,
  input  wire logic               sleep_active,
  input  wire logic [63:0]        live_ctx,
  output logic                    core_flush,
  output logic                    core_push_pc,
  output logic                    core_load_vector,
  output logic [14:0]             core_vector,
  output logic                    core_pop_pc,
  output logic                    core_restore,
  output logic [63:0]             restore_ctx,
  output logic                    core_wake,
  output logic                    core_in_service
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0]         irq_control;
  logic [7:3]         ctrl_en;
  logic               t0_flag;
  logic               ext_flag;
  logic               pc_flag;
  logic [NPERIPH-1:0] periph_en;
  logic [NPERIPH-1:0] periph_flag;
  logic               ext_edge_select;
  logic               ext_edge;
  logic               save_ctx;
  logic [63:0]        shadow_ctx;
  ciu_state_type      state;
  ciu_state_type      next_state;
  logic               wake_hold;
  logic               sleep_seen;

  logic setup_rd;
  logic acc;
  logic wr;
  logic is_ctrl;
  logic is_shadow;
  logic [2:0] sh_idx;
  logic any_req;
  logic wake_req;

  assign acc      = psel & penable;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign wr       = acc & pwrite & pstrb[0];
  assign is_ctrl  = (paddr == CIU_ADDR_CONTROL);
  assign is_shadow = (paddr >= CIU_ADDR_SHADOW_BASE) && (paddr <= CIU_ADDR_SHADOW_LAST)
                     && (paddr[1:0] == 2'b00);
  assign sh_idx   = paddr[4:2];

  // Split so every control bit group has a single writer
  assign irq_control = {ctrl_en, t0_flag, ext_flag, pc_flag};

  // ****************************************************************
  // External pin
  // ****************************************************************
  ciu_sync_edge u_ext (
    .pclk       (pclk),
    .presetn    (presetn),
    .pin        (ext_pin),
    .rising_sel (ext_edge_select),
    .edge_pulse (ext_edge)
  );

  // ****************************************************************
  // Control register: enables
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en <= CIU_CONTROL_RESET[7:3];
    end else begin
      if (wr && is_ctrl) begin
        ctrl_en <= pwdata[7:3];
      end
      if (state == CIU_FLUSH) begin
        ctrl_en[CIU_BIT_GIE] <= 1'b0;
      end else if (return_from_irq && state == CIU_RUN) begin
        ctrl_en[CIU_BIT_GIE] <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Flags: set wins over software clear
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t0_flag  <= 1'b0;
      ext_flag <= 1'b0;
    end else begin
      if (timer0_overflow) begin
        t0_flag <= 1'b1;
      end else if (wr && is_ctrl && !pwdata[CIU_BIT_T0_FLAG]) begin
        t0_flag <= 1'b0;
      end
      // Edge lands any clock, so any Q phase incl. Q4-Q1
      if (ext_edge) begin
        ext_flag <= 1'b1;
      end else if (wr && is_ctrl && !pwdata[CIU_BIT_EXT_FLAG]) begin
        ext_flag <= 1'b0;
      end
    end
  end

  // Read-only mirror of the pin-change source flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_flag <= 1'b0;
    end else begin
      pc_flag <= pin_change_any;
    end
  end

  // ****************************************************************
  // Peripheral enable, flag and option registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_en       <= '0;
      ext_edge_select <= 1'b1;
    end else if (wr && paddr == CIU_ADDR_PERIPH_EN) begin
      periph_en <= pwdata[NPERIPH-1:0];
    end else if (wr && paddr == CIU_ADDR_OPTION) begin
      ext_edge_select <= pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_flag <= '0;
    end else begin
      for (int i = 0; i < NPERIPH; i++) begin
        if (periph_event[i]) begin
          periph_flag[i] <= 1'b1;
        end else if (wr && paddr == CIU_ADDR_PERIPH_FLAG && !pwdata[i]) begin
          periph_flag[i] <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // Request gating
  // ****************************************************************
  always_comb begin
    any_req = (irq_control[CIU_BIT_T0_EN] & irq_control[CIU_BIT_T0_FLAG])
            | (irq_control[CIU_BIT_EXT_EN] & irq_control[CIU_BIT_EXT_FLAG])
            | (irq_control[CIU_BIT_PC_EN] & irq_control[CIU_BIT_PC_FLAG])
            | (irq_control[CIU_BIT_PERIPHERAL_IRQ_ENABLE] & |(periph_en & periph_flag));
    // Wake ignores global enable; only clockless peripherals count
    wake_req = (irq_control[CIU_BIT_EXT_EN] & irq_control[CIU_BIT_EXT_FLAG])
             | (irq_control[CIU_BIT_PC_EN] & irq_control[CIU_BIT_PC_FLAG])
             | (irq_control[CIU_BIT_PERIPHERAL_IRQ_ENABLE]
                & |(periph_en & periph_flag & periph_wake_capable));
  end

  // ****************************************************************
  // Vectoring sequencer, advanced on instruction cycle ticks
  // ****************************************************************
  always_comb begin
    next_state = state;
    case (state)
      CIU_RUN: begin
        // Gated by global enable: pending waits, nothing lost
        if (cycle_tick && any_req && irq_control[CIU_BIT_GIE] && !sleep_active
            && !wake_hold) begin
          next_state = CIU_FLUSH;
        end
      end
      CIU_FLUSH: begin
        if (cycle_tick) begin
          next_state = CIU_VECTOR;
        end
      end
      CIU_VECTOR: begin
        if (cycle_tick) begin
          next_state = CIU_RUN;
        end
      end
      CIU_WAKE: begin
        if (cycle_tick) begin
          next_state = CIU_RUN;
        end
      end
      default: begin
        next_state = CIU_RUN;
      end
    endcase
    if (state == CIU_RUN && sleep_seen && !sleep_active) begin
      next_state = CIU_WAKE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= CIU_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Sleep tracking: the post-sleep instruction runs first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_seen <= 1'b0;
      wake_hold  <= 1'b0;
      core_wake  <= 1'b0;
    end else begin
      sleep_seen <= sleep_active;
      core_wake  <= sleep_active & wake_req;
      wake_hold  <= (next_state == CIU_WAKE);
    end
  end

  // ****************************************************************
  // Core outputs
  // ****************************************************************
  assign save_ctx = (state == CIU_RUN) && (next_state == CIU_FLUSH);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_flush       <= 1'b0;
      core_push_pc     <= 1'b0;
      core_load_vector <= 1'b0;
      core_vector      <= CIU_IRQ_VECTOR;
      core_pop_pc      <= 1'b0;
      core_restore     <= 1'b0;
      core_in_service  <= 1'b0;
      restore_ctx      <= '0;
    end else begin
      core_flush       <= save_ctx;
      core_push_pc     <= save_ctx;
      core_load_vector <= (state == CIU_FLUSH) && cycle_tick;
      core_vector      <= CIU_IRQ_VECTOR;
      core_pop_pc      <= return_from_irq && state == CIU_RUN;
      core_restore     <= return_from_irq && state == CIU_RUN;
      restore_ctx      <= shadow_ctx;
      if (save_ctx) begin
        core_in_service <= 1'b1;
      end else if (return_from_irq && state == CIU_RUN) begin
        core_in_service <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Shadow bank
  // ****************************************************************
  logic [63:0] live_masked;
  always_comb begin
    live_masked = live_ctx;
    live_masked[15:8] = live_ctx[15:8] & CIU_STATUS_SAVE_MASK;
  end

  ciu_shadow #(
    .WIDTH (8),
    .COUNT (CIU_SHADOW_COUNT)
  ) u_shadow (
    .pclk       (pclk),
    .presetn    (presetn),
    .save       (save_ctx),
    .live_ctx   (live_masked),
    .wr_en      (wr && is_shadow),
    .wr_idx     (sh_idx),
    .wr_data    (pwdata[7:0]),
    .shadow_ctx (shadow_ctx)
  );

  // ****************************************************************
  // APB slave: one wait-free access phase
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~is_ctrl & ~is_shadow
                 & (paddr != CIU_ADDR_PERIPH_EN) & (paddr != CIU_ADDR_PERIPH_FLAG)
                 & (paddr != CIU_ADDR_OPTION) & (paddr != CIU_ADDR_CORE_STATUS);
      prdata  <= '0;
      if (setup_rd) begin
        if (is_ctrl) begin
          prdata <= {24'h000000, irq_control};
        end else if (paddr == CIU_ADDR_PERIPH_EN) begin
          prdata <= {{(32-NPERIPH){1'b0}}, periph_en};
        end else if (paddr == CIU_ADDR_PERIPH_FLAG) begin
          prdata <= {{(32-NPERIPH){1'b0}}, periph_flag};
        end else if (paddr == CIU_ADDR_OPTION) begin
          prdata <= {31'h0, ext_edge_select};
        end else if (paddr == CIU_ADDR_CORE_STATUS) begin
          prdata <= {27'h0, CIU_SHADOW_BANK == 5'h1f, core_in_service,
                     sleep_active, state};
        end else if (is_shadow) begin
          prdata <= {24'h000000, shadow_ctx[sh_idx*8 +: 8]};
        end
      end
    end
  end

endmodule
`default_nettype wire

// *** bench/ciu_checker.sv ***
/*
  Port checker for the CPU interrupt unit.
  Assumes the bind at the foot attaches it to ciu_top.
*/
`timescale 1ns/1ps
`default_nettype none
module ciu_checker
  import ciu_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        return_from_irq,
  input wire logic        sleep_active,
  input wire logic        core_flush,
  input wire logic        core_push_pc,
  input wire logic        core_load_vector,
  input wire logic [14:0] core_vector,
  input wire logic        core_pop_pc,
  input wire logic        core_restore,
  input wire logic        core_wake,
  input wire logic        core_in_service
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_vector_fixed:
    assert property (core_vector == CIU_IRQ_VECTOR) else $error("vector address wrong");
  chk_flush_push:
    assert property (core_flush |-> core_push_pc ##1 !core_flush) else $error("entry pulses wrong");
  chk_vector_follows:
    assert property (core_flush |-> ##[1:8] core_load_vector) else $error("vector load late");
  chk_no_nested_entry:
    assert property ($past(core_in_service) && core_in_service |-> !core_flush) else $error("entry in service");
  chk_return_pops:
    assert property ($rose(return_from_irq) |=> core_pop_pc && core_restore) else $error("return ignored");
  chk_restore_pair:
    assert property ($rose(core_restore) |-> core_pop_pc) else $error("restore without pop");
  chk_wake_asleep:
    assert property (core_wake |-> $past(sleep_active)) else $error("wake while awake");
  chk_apb_ready:
    assert property (psel && !penable |=> pready) else $error("no ready in access");
  chk_apb_idle:
    assert property (!psel |-> !pready) else $error("ready while idle");

  cov_entry: cover property (core_flush);
  cov_return: cover property (core_restore);
  cov_wake: cover property (core_wake);
endmodule

bind ciu_top ciu_checker u_ciu_checker (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .return_from_irq(return_from_irq), .sleep_active(sleep_active), .core_flush(core_flush),
  .core_push_pc(core_push_pc), .core_load_vector(core_load_vector), .core_vector(core_vector),
  .core_pop_pc(core_pop_pc), .core_restore(core_restore), .core_wake(core_wake),
  .core_in_service(core_in_service));
`default_nettype wire

// *** bench/ciu_core_model.sv ***
/*
  Core sequencer stand-in: instruction cycle strobe and live context.
  Assumes pclk is the Q clock, four per instruction cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module ciu_core_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  output logic             cycle_tick,
  output logic [63:0]      live_ctx
);
  // ****************************************
  // Instruction cycle
  // ****************************************
  logic [1:0] q_phase;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_phase <= 2'h0;
    end else begin
      q_phase <= q_phase + 2'h1;
    end
  end

  assign cycle_tick = (q_phase == 2'h3);
  // Status byte all ones so the unsaved bits show up
  assign live_ctx = 64'h0102_0304_0506_ff11;
endmodule
`default_nettype wire

// *** bench/ciu_tb_top.sv ***
/*
  Self-checking bench for ciu_top, one task per scenario.
  Assumes ciu_core_model supplies the cycle strobe and context.
*/
`timescale 1ns/1ps
`default_nettype none
module ciu_tb_top;
  import ciu_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00, periph_event = 8'h00, periph_wake_capable = 8'h01;
  logic [31:0] pwdata = 32'h0, rdata;
  logic [3:0]  pstrb = 4'hf;
  logic        timer0_overflow = 0, ext_pin = 1, pin_change_any = 0, return_from_irq = 0, sleep_active = 0;
  logic        err, cycle_tick;
  logic [63:0] live_ctx;
  wire  [31:0] prdata;
  wire  [63:0] restore_ctx;
  wire  [14:0] core_vector;
  wire         pready, pslverr, core_flush, core_push_pc, core_load_vector, core_pop_pc;
  wire         core_restore, core_wake, core_in_service;
  int          bad_count = 0, comparisons = 0, flush_cnt = 0;

  always #2 pclk = ~pclk;
  always @(posedge pclk) if (core_flush === 1'b1) flush_cnt <= flush_cnt + 1;

  ciu_core_model u_ciu_core_model (.pclk(pclk), .presetn(presetn), .cycle_tick(cycle_tick),
    .live_ctx(live_ctx));
  ciu_top u_ciu_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cycle_tick(cycle_tick), .timer0_overflow(timer0_overflow), .ext_pin(ext_pin),
    .pin_change_any(pin_change_any), .periph_event(periph_event), .periph_wake_capable(periph_wake_capable),
    .return_from_irq(return_from_irq), .sleep_active(sleep_active), .live_ctx(live_ctx),
    .core_flush(core_flush), .core_push_pc(core_push_pc), .core_load_vector(core_load_vector),
    .core_vector(core_vector), .core_pop_pc(core_pop_pc), .core_restore(core_restore),
    .restore_ctx(restore_ctx), .core_wake(core_wake), .core_in_service(core_in_service));

  // ****************************************
  // Shared tasks
  // ****************************************
  task tally_and_finish;
    if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) begin bad_count++; tally_and_finish; end
    rdata = prdata; err = pslverr;
    psel <= 0; penable <= 0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(0, a, 32'h0);
    chk(rdata, exp);
  endtask

  task pulse(input int s);
    @(posedge pclk);
    case (s) 0: timer0_overflow <= 1; 1: periph_event <= 8'h01; default: return_from_irq <= 1; endcase
    @(posedge pclk);
    timer0_overflow <= 0; periph_event <= 8'h00; return_from_irq <= 0;
  endtask

  // Bounded wait on flush (0), restore (1) or wake (2)
  task wait_on(input int s);
    int n;
    n = 0;
    while ((s == 0 ? core_flush : s == 1 ? core_restore : core_wake) !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk(n < 40, 1);
    if (n == 40) tally_and_finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task s_reset;
    rd_chk(CIU_ADDR_CONTROL, 32'h0);
    rd_chk(CIU_ADDR_PERIPH_EN, 32'h0);
    rd_chk(CIU_ADDR_OPTION, 32'h1);
    apb(0, 8'h30, 32'h0);
    chk(err, 1);
  endtask

  task s_flag_only;
    wr(CIU_ADDR_CONTROL, 32'h20);
    pulse(0);
    repeat (12) @(posedge pclk);
    rd_chk(CIU_ADDR_CONTROL, 32'h24);
    chk(flush_cnt, 0);
    wr(CIU_ADDR_CONTROL, 32'h0);
    rd_chk(CIU_ADDR_CONTROL, 32'h0);
  endtask

  task s_entry;
    wr(CIU_ADDR_CONTROL, 32'ha0);
    pulse(0);
    wait_on(0);
    repeat (8) @(posedge pclk);
    rd_chk(CIU_ADDR_CONTROL, 32'h24);
    rd_chk(CIU_ADDR_SHADOW_BASE, 32'h11);
    rd_chk(CIU_ADDR_SHADOW_BASE + 8'h04, 32'he7);
    wr(CIU_ADDR_CONTROL, 32'h30);
    @(posedge pclk) ext_pin <= 0;
    repeat (4) @(posedge pclk) ext_pin <= 1;
    repeat (8) @(posedge pclk);
    rd_chk(CIU_ADDR_CONTROL, 32'h32);
    chk(flush_cnt, 1);
    wr(CIU_ADDR_SHADOW_BASE, 32'h5a);
    rd_chk(CIU_ADDR_SHADOW_BASE, 32'h5a);
    wr(CIU_ADDR_CONTROL, 32'h30);
    pulse(2);
    wait_on(1);
    chk({24'h0, restore_ctx[7:0]}, 32'h5a);
    rd_chk(CIU_ADDR_CONTROL, 32'hb0);
    wr(CIU_ADDR_CONTROL, 32'h0);
  endtask

  task s_ext_pending;
    wr(CIU_ADDR_OPTION, 32'h0);
    wr(CIU_ADDR_CONTROL, 32'h10);
    @(posedge pclk) ext_pin <= 0;
    repeat (8) @(posedge pclk);
    rd_chk(CIU_ADDR_CONTROL, 32'h12);
    chk(flush_cnt, 1);
    wr(CIU_ADDR_CONTROL, 32'h92);
    wait_on(0);
    repeat (8) @(posedge pclk);
    wr(CIU_ADDR_CONTROL, 32'h10);
    pulse(2);
    wait_on(1);
    wr(CIU_ADDR_CONTROL, 32'h0);
    @(posedge pclk) ext_pin <= 1;
    repeat (8) @(posedge pclk);
    rd_chk(CIU_ADDR_CONTROL, 32'h0);
  endtask

  task s_periph_wake;
    wr(CIU_ADDR_PERIPH_EN, 32'h01);
    wr(CIU_ADDR_CONTROL, 32'h80);
    pulse(1);
    repeat (12) @(posedge pclk);
    chk(flush_cnt, 2);
    rd_chk(CIU_ADDR_PERIPH_FLAG, 32'h01);
    wr(CIU_ADDR_CONTROL, 32'h40);
    @(posedge pclk) sleep_active <= 1;
    wait_on(2);
    repeat (12) @(posedge pclk);
    chk(flush_cnt, 2);
    sleep_active <= 0;
    wr(CIU_ADDR_PERIPH_FLAG, 32'h0);
    wr(CIU_ADDR_CONTROL, 32'h0);
  endtask

  task s_pin_change;
    @(posedge pclk) pin_change_any <= 1;
    repeat (3) @(posedge pclk);
    rd_chk(CIU_ADDR_CONTROL, 32'h01);
    wr(CIU_ADDR_CONTROL, 32'h0);
    rd_chk(CIU_ADDR_CONTROL, 32'h01);
    @(posedge pclk) pin_change_any <= 0;
    repeat (3) @(posedge pclk);
    rd_chk(CIU_ADDR_CONTROL, 32'h0);
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    s_reset();
    s_flag_only();
    s_entry();
    s_ext_pending();
    s_periph_wake();
    s_pin_change();
    wr(CIU_ADDR_CONTROL, 32'he8);
    @(posedge pclk) presetn <= 0;
    repeat (3) @(posedge pclk) presetn <= 1;
    s_reset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
